/* include/tmr_pkg.sv */
// Contract
// R1 - select bit clear: count every instruction cycle
// R2 - count write: hold increments two instruction cycles
// R3 - select bit set: count external pin edges
// R4 - edge bit clear rising, set falling
// R5 - prescaler to counter or watchdog, never both
// R6 - prescaler is an 8-bit counter
// R7 - prescaler count invisible and unwritable by software
// R8 - counter ratios 1:2 through 1:256, powers of two
// R9 - count wrap FF to 00 sets flag
// R10 - enable bit clear blocks interrupt, flag still sets
// R11 - flag stays until software clears it
// R12 - counter stops during sleep
// R13 - watchdog clear zeroes prescaler, keeps assignment
// R14 - rate field n divides by 2^(n+1); the watchdog path divides by 2^n
// R15 - count write clears counter-owned prescaler
`default_nettype none
package tmr_pkg;
  // ==========================================
  // register word indices (byte address is four times these)
  localparam logic [3:0] COUNT_IDX = 4'h1;
  localparam logic [3:0] OPTION_IDX = 4'h2;
  localparam logic [3:0] STATUS_IDX = 4'h3;
  localparam logic [3:0] MASK_IDX = 4'h4;
  localparam logic [3:0] INTERRUPT_CONTROL_IDX = 4'hB;
  // ==========================================
  // option register fields
  localparam int OPT_CSS_BIT = 5;
  localparam int OPT_EDGE_BIT = 4;
  localparam int OPT_PSA_BIT = 3;
  localparam int OPT_RATE_LSB = 0;
  localparam int OPT_RATE_W = 3;
  localparam int OPT_W = 6;
  localparam logic [5:0] OPTION_RST = 6'h3F;
  // ==========================================
  // interrupt control, status and mask fields
  localparam int ICTL_EN_BIT = 5;
  localparam int ICTL_FLAG_BIT = 2;
  localparam int STAT_OVF_BIT = 0;
  localparam logic FLAG_RST = 1'b0;
  localparam logic EN_RST = 1'b0;
  // ==========================================
  // counter values and timing
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [1:0] WR_INHIBIT_CYC = 2'h2;
  localparam int CYC_CLKS = 4;
  localparam int PRE_W = 8;
endpackage
`default_nettype wire

/* include/tmr_pre_if.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// link between the timer core and the shared prescaler
interface tmr_pre_if;
  logic tick_in;
  logic clear;
  logic to_wdt;
  logic [2:0] rate;
  logic tick_out;
  modport ctrl (output tick_in, output clear, output to_wdt, output rate, input tick_out);
  modport pre (input tick_in, input clear, input to_wdt, input rate, output tick_out);
endinterface
`default_nettype wire

/* hw/tmr_cyc_div.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// instruction cycle enable: one pulse every DIV clocks
module tmr_cyc_div import tmr_pkg::*; #(
  parameter int DIV = CYC_CLKS
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // one-cycle enable
  output logic en
);
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  logic [CW-1:0] cnt_ff;
  logic en_ff;
  wire logic last = (cnt_ff == CW'(DIV - 1));

  // free-running phase counter
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= '0;
      en_ff <= 1'b0;
    end else begin
      cnt_ff <= last ? '0 : cnt_ff + 1'b1;
      en_ff <= last;
    end
  end
  assign en = en_ff;
endmodule
`default_nettype wire

/* hw/tmr_prescaler.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// shared prescaler; its count has no read or load path, only a clear
module tmr_prescaler import tmr_pkg::*; #(
  parameter int W = PRE_W
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // control from the timer core
  tmr_pre_if.pre bus
);
  logic [W-1:0] cnt_ff;
  logic tick_ff;
  wire logic [W-1:0] nxt_cnt = cnt_ff + 1'b1;

  // span of one output period, minus one
  function automatic logic [W-1:0] rate_mask(input logic [2:0] rate, input logic to_wdt);
    logic [W:0] span;
    span = '0;
    span = {{W{1'b0}}, 1'b1} << (to_wdt ? {1'b0, rate} : {1'b0, rate} + 4'h1);
    return W'(span - 1'b1);
  endfunction

  // R8 power-of-two ratios
  // R14 ratio select
  wire logic [W-1:0] mask = rate_mask(bus.rate, bus.to_wdt);
  wire logic hit = bus.tick_in && ((nxt_cnt & mask) == '0);

  // R6 eight-bit count
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= bus.clear ? '0 : (bus.tick_in ? nxt_cnt : cnt_ff);
      tick_ff <= hit && !bus.clear;
    end
  end
  assign bus.tick_out = tick_ff;

  // R13 clear zeroes count
  pre_clear_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    bus.clear |=> (cnt_ff == '0)) // R13
    else $error("prescaler count not cleared");
  // R8 output only on wrap
  pre_ratio_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    tick_ff |-> (($past(nxt_cnt) & $past(mask)) == '0)) // R8
    else $error("prescaler tick off its ratio");
endmodule
`default_nettype wire

/* hw/tmr_timer0.sv */
// Local design decision: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// 8-bit timer/counter with shared prescaler, Avalon-MM slave
module tmr_timer0 import tmr_pkg::*; #(
  parameter int CYC_DIV = CYC_CLKS
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // external count pin, asynchronous
  input wire logic count_pin,
  // core status, same clock
  input wire logic sleep_in,
  input wire logic wdt_clear,
  input wire logic wdt_src_tick,
  // outputs
  output logic wdt_tick,
  output logic irq
);

  // ==========================================
  // state
  logic wait_ff;
  logic [31:0] rdata_ff;
  logic [7:0] count_ff;
  logic [OPT_W-1:0] option_ff;
  logic flag_ff;
  logic ovf_en_ff;
  logic [1:0] inhib_ff;
  logic pin_s1_ff;
  logic pin_s2_ff;
  logic pin_s3_ff;
  logic [1:0] pin_arm_ff;
  logic irq_ff;
  logic wdt_tick_ff;
  logic cyc_en;

  tmr_pre_if pre_bus();

  // ==========================================
  // instruction cycle enable
  tmr_cyc_div #(
    .DIV(CYC_DIV)
  ) u_div (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .en(cyc_en)
  );

  // ==========================================
  // shared prescaler
  tmr_prescaler #(
    .W(PRE_W)
  ) u_pre (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .bus(pre_bus.pre)
  );

  // ==========================================
  // bus decode
  function automatic logic hits(input logic [3:0] addr, input logic [3:0] idx);
    return addr == idx;
  endfunction

  wire logic req = avs_read || avs_write;
  // a request is answered on the edge where the master sees wait low
  wire logic take = req && !wait_ff;
  wire logic wr_take = avs_write && !wait_ff && avs_byteenable[0];
  wire logic [7:0] wbyte = avs_writedata[7:0];
  wire logic sel_count = hits(avs_address, COUNT_IDX);
  wire logic sel_option = hits(avs_address, OPTION_IDX);
  wire logic sel_status = hits(avs_address, STATUS_IDX);
  wire logic sel_mask = hits(avs_address, MASK_IDX);
  wire logic sel_interrupt_control = hits(avs_address, INTERRUPT_CONTROL_IDX);
  wire logic wr_count = wr_take && sel_count;
  wire logic wr_option = wr_take && sel_option;
  wire logic wr_status = wr_take && sel_status;
  wire logic wr_mask = wr_take && sel_mask;
  wire logic wr_interrupt_control = wr_take && sel_interrupt_control;

  // ==========================================
  // option fields
  wire logic opt_css = option_ff[OPT_CSS_BIT];
  wire logic opt_edge = option_ff[OPT_EDGE_BIT];
  wire logic opt_psa = option_ff[OPT_PSA_BIT];
  wire logic [2:0] opt_rate = option_ff[OPT_RATE_LSB +: OPT_RATE_W];

  // ==========================================
  // R7 no prescaler readback
  // read mux; prescaler count deliberately absent
  logic [7:0] interrupt_control_rd;
  assign interrupt_control_rd = (8'(ovf_en_ff) << ICTL_EN_BIT) | (8'(flag_ff) << ICTL_FLAG_BIT);
  wire logic [31:0] rd_mux =
    sel_count ? {24'h000000, count_ff} :
    sel_option ? {26'h0000000, option_ff} :
    sel_status ? (32'(flag_ff) << STAT_OVF_BIT) :
    sel_mask ? (32'(ovf_en_ff) << STAT_OVF_BIT) :
    sel_interrupt_control ? {24'h000000, interrupt_control_rd} :
    32'h00000000;

  // one wait cycle per access, then release for the answering edge
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wait_ff <= 1'b1;
      rdata_ff <= 32'h00000000;
    end else begin
      wait_ff <= !(req && wait_ff);
      if (avs_read && wait_ff) begin
        rdata_ff <= rd_mux;
      end
    end
  end

  // ==========================================
  // external pin: two-flop sync, third flop for edge detect
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pin_s1_ff <= 1'b0;
      pin_s2_ff <= 1'b0;
      pin_s3_ff <= 1'b0;
    end else begin
      pin_s1_ff <= count_pin;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
    end
  end

  // edges count only once all three flops hold pin samples, so a pin that
  // idles high cannot fake a rising edge just after reset
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pin_arm_ff <= 2'h0;
    end else if (pin_arm_ff != 2'h3) begin
      pin_arm_ff <= pin_arm_ff + 2'h1;
    end
  end
  wire logic pin_armed = (pin_arm_ff == 2'h3);

  // R4 edge polarity
  wire logic pin_rise = pin_armed && pin_s2_ff && !pin_s3_ff;
  wire logic pin_fall = pin_armed && !pin_s2_ff && pin_s3_ff;
  wire logic ext_tick = opt_edge ? pin_fall : pin_rise;

  // R1 timer source
  // R3 counter source
  wire logic raw_tick = opt_css ? ext_tick : cyc_en;

  // ==========================================
  // prescaler hookup
  // R5 exclusive assignment
  assign pre_bus.to_wdt = opt_psa;
  assign pre_bus.rate = opt_rate;
  assign pre_bus.tick_in = opt_psa ? wdt_src_tick : (raw_tick && !sleep_in);
  // R13 watchdog clear
  // R15 count write clear
  assign pre_bus.clear = opt_psa ? wdt_clear : wr_count;

  // ==========================================
  // increment gating
  // R12 stopped in sleep
  // R2 write inhibit window
  wire logic inc_src = opt_psa ? raw_tick : pre_bus.tick_out;
  wire logic inhibited = (inhib_ff != 2'h0);
  wire logic inc = inc_src && !sleep_in && !inhibited;
  // R9 wrap detect
  wire logic ovf = inc && (count_ff == COUNT_MAX);

  // ==========================================
  // count register; a software write wins over an increment
  logic [7:0] nxt_count;
  logic [1:0] nxt_inhib;
  always_comb begin
    nxt_count = count_ff;
    nxt_inhib = inhib_ff;
    if (wr_count) begin
      nxt_count = wbyte;
      nxt_inhib = WR_INHIBIT_CYC;
    end else begin
      if (inc) begin
        nxt_count = count_ff + 8'h01;
      end
      if (cyc_en && inhibited) begin
        nxt_inhib = inhib_ff - 2'h1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      count_ff <= COUNT_RST;
      inhib_ff <= 2'h0;
    end else begin
      count_ff <= nxt_count;
      inhib_ff <= nxt_inhib;
    end
  end

  // ==========================================
  // option register
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      option_ff <= OPTION_RST;
    end else if (wr_option) begin
      option_ff <= wbyte[OPT_W-1:0];
    end
  end

  // ==========================================
  // overflow flag and enable
  // flag is cleared by writing one to status or zero to the control copy;
  // an overflow in the same cycle wins so no event is lost
  wire logic flag_clr = (wr_status && wbyte[STAT_OVF_BIT]) ||
    (wr_interrupt_control && !wbyte[ICTL_FLAG_BIT]);
  wire logic flag_sw_set = wr_interrupt_control && wbyte[ICTL_FLAG_BIT];
  // R11 sticky flag
  wire logic nxt_flag = ovf || flag_sw_set || (flag_ff && !flag_clr);
  wire logic nxt_en = wr_interrupt_control ? wbyte[ICTL_EN_BIT] :
    (wr_mask ? wbyte[STAT_OVF_BIT] : ovf_en_ff);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      flag_ff <= FLAG_RST;
      ovf_en_ff <= EN_RST;
    end else begin
      flag_ff <= nxt_flag;
      ovf_en_ff <= nxt_en;
    end
  end

  // ==========================================
  // outputs, each from a flop
  // R10 enable gates request
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irq_ff <= 1'b0;
      wdt_tick_ff <= 1'b0;
    end else begin
      irq_ff <= flag_ff && ovf_en_ff;
      wdt_tick_ff <= opt_psa && pre_bus.tick_out;
    end
  end

  assign avs_readdata = rdata_ff;
  assign avs_waitrequest = wait_ff;
  assign irq = irq_ff;
  assign wdt_tick = wdt_tick_ff;

  // ==========================================
  // checks
  // R2 write holds written value
  write_inhibit_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    wr_count |=> (count_ff == $past(wbyte)) && (inhib_ff == 2'h2)) // R2
    else $error("count write or inhibit window wrong");

  // R2 no increment while inhibited
  inhibit_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (inhibited && !wr_count) |=> (count_ff == $past(count_ff))) // R2
    else $error("count moved inside inhibit window");

  // R1 timer mode counts each cycle
  timer_mode_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (!opt_css && opt_psa && cyc_en && !sleep_in && !inhibited && !wr_count)
    |=> (count_ff == $past(count_ff) + 8'h01)) // R1
    else $error("timer mode missed an instruction cycle");

  // R3 counter mode ignores instruction cycles
  counter_mode_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (opt_css && opt_psa && !ext_tick && !wr_count)
    |=> (count_ff == $past(count_ff))) // R3
    else $error("counter mode moved without pin edge");

  // R4 chosen edge counts
  pin_edge_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (opt_css && opt_psa && !sleep_in && !inhibited && !wr_count &&
    (opt_edge ? pin_fall : pin_rise)) |=> (count_ff == $past(count_ff) + 8'h01)) // R4
    else $error("selected pin edge not counted");

  // R9 wrap sets flag
  wrap_flag_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (ovf && !wr_count) |=> (flag_ff && (count_ff == 8'h00))) // R9
    else $error("wrap did not set flag");

  // R11 flag holds without clear
  flag_sticky_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (flag_ff && !flag_clr) |=> flag_ff) // R11
    else $error("flag dropped without software clear");

  // R10 interrupt follows enable
  irq_gate_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    !ovf_en_ff |=> !irq_ff) // R10
    else $error("interrupt raised while disabled");

  // R12 sleep freezes count
  sleep_stop_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (sleep_in && !wr_count) |=> (count_ff == $past(count_ff))) // R12
    else $error("count moved during sleep");

  // R5 watchdog tick gated
  wdt_gate_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    !opt_psa |=> !wdt_tick_ff) // R5
    else $error("watchdog tick while prescaler owned by counter");

  // R15 write resets prescaler
  count_wr_clear_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (wr_count && !opt_psa) |=> !pre_bus.tick_out) // R15
    else $error("prescaler ticked right after count write");

  // R8 no back-to-back ticks
  ratio_gap_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    !opt_psa ##1 (!opt_psa && pre_bus.tick_out) |=> !pre_bus.tick_out) // R8
    else $error("prescaled tick on consecutive cycles");

  // R10 flag sets while masked
  masked_flag_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (ovf && !ovf_en_ff) |=> flag_ff) // R10
    else $error("masked overflow did not set flag");

  // R9 flag needs a cause
  flag_cause_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (!flag_ff && !ovf && !flag_sw_set) |=> !flag_ff) // R9
    else $error("flag rose without overflow");

  // bus answers after exactly one wait cycle
  bus_wait_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (req && wait_ff) |=> !wait_ff ##1 wait_ff)
    else $error("wait request timing wrong");

  overflow_seen_c: cover property (@(posedge ref_clk) disable iff (!nrst) ovf);
  irq_raised_c: cover property (@(posedge ref_clk) disable iff (!nrst) $rose(irq_ff));
  ext_count_c: cover property (@(posedge ref_clk) disable iff (!nrst)
    opt_css && inc);
  pre_timer_c: cover property (@(posedge ref_clk) disable iff (!nrst)
    !opt_psa && pre_bus.tick_out && (opt_rate == 3'h7));
  wdt_tick_c: cover property (@(posedge ref_clk) disable iff (!nrst) wdt_tick_ff);
endmodule
`default_nettype wire

/* verif/tmr_pin_src.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// external count source: idle level plus bursts of pulses
module tmr_pin_src (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // command from the bench
  input wire logic idle_lvl,
  input wire logic start,
  input wire logic [7:0] pulses,
  // pin and status
  output logic count_pin,
  output logic busy
);
  logic [7:0] left_ff;
  logic [2:0] ph_ff;
  // 3 clocks away and 3 back, well over the 2-clock minimum spacing
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      left_ff <= 8'h00;
      ph_ff <= 3'h0;
    end else if (start) begin
      left_ff <= pulses;
      ph_ff <= 3'h0;
    end else if (left_ff != 8'h00) begin
      ph_ff <= (ph_ff == 3'h5) ? 3'h0 : ph_ff + 3'h1;
      if (ph_ff == 3'h5) begin
        left_ff <= left_ff - 8'h01;
      end
    end
  end
  // a pulse is the inverse of the idle level
  assign count_pin = (left_ff != 8'h00 && ph_ff < 3'h3) ? !idle_lvl : idle_lvl;
  assign busy = (left_ff != 8'h00);
endmodule
`default_nettype wire

/* verif/tmr_timer0_test.sv */
`timescale 1ns/1ps
`default_nettype none
module tmr_timer0_test import tmr_pkg::*;;
  logic ref_clk, nrst, avs_read, avs_write, sleep_in, wdt_clear, wdt_src_tick;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata;
  logic avs_waitrequest, count_pin, wdt_tick, irq, idle_lvl, start, busy;
  logic [7:0] pulses, q, a;
  int fail_count = 0;
  int n_checks = 0;
  int wd_seen = 0;
  // ==========================================
  // design, far-side source, clock
  tmr_timer0 #(.CYC_DIV(4)) i_dut (.ref_clk(ref_clk), .nrst(nrst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .count_pin(count_pin), .sleep_in(sleep_in), .wdt_clear(wdt_clear),
    .wdt_src_tick(wdt_src_tick), .wdt_tick(wdt_tick), .irq(irq));
  tmr_pin_src i_src (.ref_clk(ref_clk), .nrst(nrst), .idle_lvl(idle_lvl),
    .start(start), .pulses(pulses), .count_pin(count_pin), .busy(busy));
  always #2 ref_clk = ~ref_clk;
  // count prescaled watchdog ticks as they appear
  always @(posedge ref_clk) if (wdt_tick === 1'b1) wd_seen++;
  // ==========================================
  // helpers
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask
  task automatic chk_rng(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
    n_checks++;
    if ($isunknown(got) || got < lo || got > hi) begin
      $display("Error at %0t: got %h outside %h..%h", $time, got, lo, hi);
      fail_count++;
    end
  endtask
  // one avalon access; held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] ad, input logic [7:0] d,
                     input logic [3:0] be, output logic [7:0] r);
    avs_address <= ad;
    avs_writedata <= {24'h000000, d};
    avs_byteenable <= be;
    avs_read <= !wr;
    avs_write <= wr;
    // only the watchdog process ends a wait that never answers
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'b0);
    r = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [3:0] ad, input logic [7:0] d);
    logic [7:0] r;
    bus(1'b1, ad, d, 4'hF, r);
  endtask
  task automatic rd(input logic [3:0] ad, output logic [7:0] r);
    bus(1'b0, ad, 8'h00, 4'hF, r);
  endtask
  task automatic src(input int n);
    repeat (n) begin
      wdt_src_tick <= 1'b1;
      @(posedge ref_clk);
      wdt_src_tick <= 1'b0;
      cyc(3);
    end
  endtask
  task automatic wclr();
    wdt_clear <= 1'b1;
    @(posedge ref_clk);
    wdt_clear <= 1'b0;
    cyc(2);
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset();
    rd(OPTION_IDX, q);
    chk(q, {2'h0, OPTION_RST});
    rd(INTERRUPT_CONTROL_IDX, q);
    chk(q, 8'h00);
    rd(4'h0, q);
    chk(q, 8'h00);
    wr(4'h0, 8'hFF);
    rd(4'h0, q);
    chk(q, 8'h00);
    bus(1'b1, COUNT_IDX, 8'h55, 4'hE, q);
    rd(COUNT_IDX, q);
    chk(q, COUNT_RST);
  endtask
  task automatic t_timer();
    wr(OPTION_IDX, 8'h08);
    wr(COUNT_IDX, 8'h10);
    rd(COUNT_IDX, q);
    chk(q, 8'h10);
    rd(COUNT_IDX, a);
    cyc(40);
    rd(COUNT_IDX, q);
    chk_rng(q - a, 8'h0A, 8'h0B);
    sleep_in <= 1'b1;
    cyc(2);
    rd(COUNT_IDX, a);
    cyc(40);
    rd(COUNT_IDX, q);
    chk(q, a);
    sleep_in <= 1'b0;
  endtask
  task automatic t_presc();
    for (int r = 0; r < 8; r++) begin
      wr(OPTION_IDX, 8'(r));
      wr(COUNT_IDX, 8'h00);
      cyc(16);
      rd(COUNT_IDX, a);
      cyc(16 << (r + 1));
      rd(COUNT_IDX, q);
      chk_rng(q - a, 8'h04, 8'h05);
    end
  endtask
  task automatic t_pin();
    int n;
    wr(OPTION_IDX, 8'h28);
    wr(COUNT_IDX, 8'h00);
    cyc(12);
    idle_lvl <= 1'b1;
    cyc(8);
    rd(COUNT_IDX, q);
    chk(q, 8'h01);
    wr(OPTION_IDX, 8'h38);
    idle_lvl <= 1'b0;
    cyc(8);
    rd(COUNT_IDX, q);
    chk(q, 8'h02);
    idle_lvl <= 1'b1;
    cyc(8);
    rd(COUNT_IDX, q);
    chk(q, 8'h02);
    pulses <= 8'h05;
    start <= 1'b1;
    @(posedge ref_clk);
    start <= 1'b0;
    cyc(1);
    n = 0;
    while (busy && n < 200) begin
      @(posedge ref_clk);
      n++;
    end
    cyc(8);
    rd(COUNT_IDX, q);
    chk(q, 8'h07);
  endtask
  task automatic t_irq();
    wr(OPTION_IDX, 8'h08);
    wr(MASK_IDX, 8'h00);
    wr(STATUS_IDX, 8'h01);
    wr(COUNT_IDX, 8'hFD);
    cyc(30);
    rd(INTERRUPT_CONTROL_IDX, q);
    chk(q, 8'h04);
    chk({7'h00, irq}, 8'h00);
    wr(MASK_IDX, 8'h01);
    cyc(2);
    chk({7'h00, irq}, 8'h01);
    cyc(40);
    rd(INTERRUPT_CONTROL_IDX, q);
    chk(q, 8'h24);
    wr(STATUS_IDX, 8'h01);
    cyc(2);
    chk({7'h00, irq}, 8'h00);
    rd(STATUS_IDX, q);
    chk(q, 8'h00);
    wr(INTERRUPT_CONTROL_IDX, 8'h04);
    rd(STATUS_IDX, q);
    chk(q, 8'h01);
    wr(INTERRUPT_CONTROL_IDX, 8'h00);
  endtask
  task automatic t_wdt();
    int b;
    wr(OPTION_IDX, 8'h09);
    wclr();
    b = wd_seen;
    src(8);
    cyc(4);
    chk(8'(wd_seen - b), 8'h04);
    wclr();
    src(1);
    wclr();
    src(1);
    cyc(4);
    chk(8'(wd_seen - b), 8'h04);
    rd(OPTION_IDX, q);
    chk(q, 8'h09);
    wr(OPTION_IDX, 8'h01);
    src(4);
    cyc(4);
    chk(8'(wd_seen - b), 8'h04);
  endtask
  // ==========================================
  // verdict and run
  task automatic report_and_stop();
    if (fail_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #400000;
    fail_count++;
    $display("Error at %0t: timeout", $time);
    report_and_stop();
  end
  initial begin
    ref_clk = 1'b0;
    nrst = 1'b0;
    {avs_read, avs_write, sleep_in, wdt_clear, wdt_src_tick} = 5'h00;
    {avs_address, avs_byteenable, avs_writedata} = '0;
    {idle_lvl, start, pulses} = '0;
    cyc(4);
    nrst <= 1'b1;
    @(posedge ref_clk);
    t_reset();
    t_timer();
    t_presc();
    t_pin();
    t_irq();
    t_wdt();
    report_and_stop();
  end
endmodule
`default_nettype wire
